/* logic/shared_mem_select_n_ctrl.sv */
// shared 8k x 8 memory controller between host bus and coax line controller
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
module shared_mem_select_n_ctrl
   import shared_mem_select_n_ctrl_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   srst,
   // host bus side
   input  wire logic                   shared_mem_select_n,
   input  wire logic [2:0]             host_status,
   input  wire logic [HOST_ADDR_W-1:0] host_addr,
   input  wire logic [DATA_W-1:0]      host_wdata_low,
   input  wire logic [DATA_W-1:0]      host_wdata_high,
   input  wire logic                   delayed_latch_strobe,
   output logic                        shared_mem_host_ready,
   output logic [DATA_W-1:0]           host_rdata,
   output logic                        host_lane_low_en,
   output logic                        host_lane_high_en,
   // coax line controller strobes (asynchronous to clk)
   input  wire logic                   write_addr_low_strobe_n,
   input  wire logic                   write_addr_high_strobe_n,
   input  wire logic                   write_byte_strobe_n,
   input  wire logic                   read_request_strobe_n,
   input  wire logic                   read_byte_strobe_n,
   input  wire logic [DATA_W-1:0]      coax_wdata,
   output logic [DATA_W-1:0]           coax_rdata,
   output logic                        coax_rdata_oe,
   // shared memory
   output logic                        coax_addr_enable_n,
   output logic                        host_addr_enable_n,
   output logic [MEM_ADDR_W-1:0]       shared_mem_addr_bus,
   output logic                        mem_cs_n,
   output logic                        mem_we_n,
   output logic                        mem_oe_n,
   output logic [DATA_W-1:0]           mem_wdata,
   input  wire logic [DATA_W-1:0]      mem_rdata
);

   // ----------------------------------------------------------------
   // coax-side register latches
   // ----------------------------------------------------------------
   // these sit in the coax controller's strobe domain, like the external
   // latches they replace; flags are set and cleared by clk, set once a strobe edge is synchronised
   logic [DATA_W-1:0]    addr_low_q;
   logic [ADDR_HI_W-1:0] addr_high_q;
   logic [DATA_W-1:0]    wbyte_q;

   // address registers must be loaded before a request is issued
   always_ff @(posedge write_addr_low_strobe_n) begin
      addr_low_q <= coax_wdata;
   end

   always_ff @(posedge write_addr_high_strobe_n) begin
      addr_high_q <= coax_wdata[ADDR_HI_W-1:0];
   end

   always_ff @(posedge write_byte_strobe_n) begin
      wbyte_q <= coax_wdata;
   end

   // read byte register drives the coax data bus while its strobe is low
   assign coax_rdata_oe = ~read_byte_strobe_n;

   // ----------------------------------------------------------------
   // state and next state
   // ----------------------------------------------------------------
   ctrl_state_t st;
   ctrl_state_t next_st;
   mem_port_t   mem_q;
   mem_port_t   next_mem;

   function automatic logic host_cycle(input logic sel_n, input logic [2:0] status);
      host_cycle = ~sel_n && (status == ST_MEM_READ || status == ST_MEM_WRITE ||
                              status == ST_FETCH);
   endfunction

   wire logic host_want  = host_cycle(shared_mem_select_n, host_status) && !st.host_ready;
   // a trailing strobe edge counts once stages two and three agree high while the
   // filtered level was still low; the filter idles high so reset makes no false edge
   wire logic rd_rise    = st.rd_sync[2] & st.rd_sync[1] & ~st.rd_filt;
   wire logic wr_rise    = st.wr_sync[2] & st.wr_sync[1] & ~st.wr_filt;
   wire logic req_seen   = rd_rise | wr_rise;
   wire logic coax_pend  = st.coax_req | req_seen;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_st  = st;
      next_mem = mem_q;
      // three-stage synchronisers for the read request and write byte strobes
      next_st.rd_sync = {st.rd_sync[1:0], read_request_strobe_n};
      next_st.wr_sync = {st.wr_sync[1:0], write_byte_strobe_n};
      if (st.rd_sync[2] == st.rd_sync[1]) begin
         next_st.rd_filt = st.rd_sync[2];
      end
      if (st.wr_sync[2] == st.wr_sync[1]) begin
         next_st.wr_filt = st.wr_sync[2];
      end
      if (req_seen) begin
         next_st.coax_req = 1'b1;
         next_st.coax_wr  = wr_rise;                        // set with the request
         next_st.coax_addr  = {addr_high_q, addr_low_q};
         next_st.coax_wdata = wbyte_q;
      end
      // ready latch is dropped by the next host cycle's strobe
      if (delayed_latch_strobe) begin
         next_st.host_ready = 1'b0;
      end
      case (st.state)
         S_IDLE: begin
            next_mem.cs_n = 1'b1;
            next_mem.we_n = 1'b1;
            next_mem.oe_n = 1'b1;
            // host wins a tie; coax flag stays pending
            if (host_want) begin
               next_st.state      = S_ADDR;
               next_st.owner_coax = 1'b0;
               next_st.is_write   = (host_status == ST_MEM_WRITE);
               next_st.lane_odd   = host_addr[0];
            end else if (st.coax_req) begin
               next_st.state      = S_ADDR;
               next_st.owner_coax = 1'b1;
               next_st.is_write   = st.coax_wr;
               next_st.coax_req   = req_seen;
               next_st.coax_wr    = req_seen ? wr_rise : 1'b0;
            end
         end
         S_ADDR: begin
            // clock 1 of 3: address on bus, chip select and strobe
            next_st.state  = S_DATA;
            next_mem.cs_n  = 1'b0;
            next_mem.we_n  = ~st.is_write;
            next_mem.oe_n  = st.is_write;
            next_mem.wdata = st.owner_coax ? st.coax_wdata :
                             (st.lane_odd ? host_wdata_high : host_wdata_low);
         end
         S_DATA: begin
            // clock 2 of 3: capture returning byte
            next_st.state = S_DONE;
            if (st.owner_coax) begin
               next_st.coax_rdata = st.is_write ? st.coax_wdata : mem_rdata;
            end else if (!st.is_write) begin
               next_st.host_rdata = mem_rdata;
            end
         end
         S_DONE: begin
            // clock 3 of 3: release memory, report ready to host
            next_st.state = S_IDLE;
            next_mem.cs_n = 1'b1;
            next_mem.we_n = 1'b1;
            next_mem.oe_n = 1'b1;
            if (!st.owner_coax) begin
               next_st.host_ready = 1'b1;
            end
         end
         default: begin
            next_st.state = S_IDLE;
         end
      endcase
   end

   // registered state; reset gives idle with memory deselected
   always_ff @(posedge clk) begin
      if (srst) begin
         st       <= '0;
         st.state <= S_IDLE;
         st.rd_sync <= 3'h7;
         st.wr_sync <= 3'h7;
         st.rd_filt <= 1'b1;
         st.wr_filt <= 1'b1;
         mem_q    <= '0;
         mem_q.cs_n <= 1'b1;
         mem_q.we_n <= 1'b1;
         mem_q.oe_n <= 1'b1;
      end else begin
         st    <= next_st;
         mem_q <= next_mem;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // exactly one address source enabled while a cycle is running
   wire logic busy = (st.state != S_IDLE);
   assign coax_addr_enable_n = ~(busy & st.owner_coax);
   assign host_addr_enable_n = ~(busy & ~st.owner_coax);
   // host address only gated, never stored
   assign shared_mem_addr_bus = ~coax_addr_enable_n ? st.coax_addr :
                                (~host_addr_enable_n ? host_addr[MEM_ADDR_W-1:0] : '0);
   assign mem_cs_n  = mem_q.cs_n;
   assign mem_we_n  = mem_q.we_n;
   assign mem_oe_n  = mem_q.oe_n;
   assign mem_wdata = mem_q.wdata;
   assign shared_mem_host_ready = st.host_ready;
   assign host_rdata            = st.host_rdata;
   assign coax_rdata            = st.coax_rdata;
   // one byte lane only
   assign host_lane_low_en  = (busy | st.host_ready) & ~st.owner_coax & ~st.lane_odd;
   assign host_lane_high_en = (busy | st.host_ready) & ~st.owner_coax &  st.lane_odd;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_start;
      st.state == S_IDLE ##1 st.state == S_ADDR;
   endsequence

   a_three_clock_cycle: assert property (@(posedge clk) disable iff (srst)
      s_start |=> st.state == S_DATA ##1 st.state == S_DONE ##1 st.state == S_IDLE)
      else $error("access did not finish in three clocks");

   a_one_addr_enable: assert property (@(posedge clk) disable iff (srst)
      !(coax_addr_enable_n == 1'b0 && host_addr_enable_n == 1'b0))
      else $error("both address enables active");

   a_one_lane_only: assert property (@(posedge clk) disable iff (srst)
      !(host_lane_low_en && host_lane_high_en))
      else $error("both host lanes enabled");

   a_ready_after_host: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_DONE && !st.owner_coax && !delayed_latch_strobe) |=> shared_mem_host_ready)
      else $error("host ready not raised");

   a_ready_cleared: assert property (@(posedge clk) disable iff (srst)
      (delayed_latch_strobe && st.state != S_DONE) |=> !shared_mem_host_ready)
      else $error("ready not cleared by strobe");

   a_host_read_latch: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_DATA && !st.owner_coax && !st.is_write) |=> host_rdata == $past(mem_rdata))
      else $error("host read byte not latched");

   a_coax_read_latch: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_DATA && st.owner_coax && !st.is_write) |=> coax_rdata == $past(mem_rdata))
      else $error("coax read byte not latched");

   a_coax_flag_clear: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_IDLE && !host_want && st.coax_req && !req_seen) |=> !st.coax_req)
      else $error("coax request flag not cleared");

   a_host_first: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_IDLE && host_want && st.coax_req) |=> (!st.owner_coax && st.coax_req))
      else $error("tie not resolved in host favour");

   a_host_start: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_IDLE && host_want) |=> st.state == S_ADDR)
      else $error("host access did not start");

   a_req_sync: assert property (@(posedge clk) disable iff (srst)
      req_seen |=> st.coax_req || st.state == S_ADDR)
      else $error("synchronised request lost");

   // memory strobes follow the sequencer state
   a_idle_mem_off: assert property (@(posedge clk) disable iff (srst)
      st.state == S_IDLE |-> mem_cs_n && mem_we_n && mem_oe_n)
      else $error("memory selected while idle");

   a_data_cs_low: assert property (@(posedge clk) disable iff (srst)
      st.state == S_DATA |-> !mem_cs_n)
      else $error("memory not selected in data clock");

   a_done_cs_held: assert property (@(posedge clk) disable iff (srst)
      st.state == S_DONE |-> !mem_cs_n)
      else $error("memory released before last clock");

   a_write_strobes: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_DATA && st.is_write) |-> !mem_we_n && mem_oe_n)
      else $error("write strobes wrong");

   a_read_strobes: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_DATA && !st.is_write) |-> mem_we_n && !mem_oe_n)
      else $error("read strobes wrong");

   // address source selection
   a_idle_no_enable: assert property (@(posedge clk) disable iff (srst)
      st.state == S_IDLE |-> coax_addr_enable_n && host_addr_enable_n)
      else $error("address enable active while idle");

   a_busy_one_enable: assert property (@(posedge clk) disable iff (srst)
      st.state != S_IDLE |-> (coax_addr_enable_n ^ host_addr_enable_n))
      else $error("not exactly one address enable while busy");

   a_host_addr_gate: assert property (@(posedge clk) disable iff (srst)
      !host_addr_enable_n |-> shared_mem_addr_bus == host_addr[MEM_ADDR_W-1:0])
      else $error("host address not gated through");

   a_coax_addr_gate: assert property (@(posedge clk) disable iff (srst)
      !coax_addr_enable_n |-> shared_mem_addr_bus == st.coax_addr)
      else $error("coax address not on bus");

   // coax service and host handshake details
   sequence s_coax_taken;
      st.state == S_IDLE && !host_want && st.coax_req && !req_seen;
   endsequence

   a_coax_no_ready: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_DONE && st.owner_coax && !st.host_ready) |=> !shared_mem_host_ready)
      else $error("coax access raised host ready");

   a_coax_wr_clear: assert property (@(posedge clk) disable iff (srst)
      s_coax_taken |=> !st.coax_wr)
      else $error("coax write flag not cleared");

   a_host_odd_lane: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_IDLE && host_want && host_addr[0]) |=> host_lane_high_en && !host_lane_low_en)
      else $error("odd address did not pick high lane");

   a_coax_write_data: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_ADDR && st.owner_coax && st.is_write) |=> mem_wdata == $past(st.coax_wdata))
      else $error("coax write byte not driven");

   a_coax_wr_rise: assert property (@(posedge clk) disable iff (srst)
      wr_rise |=> st.coax_wr || (st.state == S_ADDR && st.is_write))
      else $error("write strobe did not set write flag");

   a_no_status_start: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_IDLE && !st.coax_req && !host_cycle(shared_mem_select_n, host_status))
      |=> st.state == S_IDLE)
      else $error("access started without request");

   a_coax_write_echo: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_DATA && st.owner_coax && st.is_write) |=> coax_rdata == $past(st.coax_wdata))
      else $error("coax data register not loaded on write");

   a_host_high_byte: assert property (@(posedge clk) disable iff (srst)
      (st.state == S_ADDR && !st.owner_coax && st.is_write && st.lane_odd) |=>
      mem_wdata == $past(host_wdata_high))
      else $error("odd host write took wrong lane");

endmodule // shared_mem_select_n_ctrl

/* logic/shared_mem_select_n_ctrl_pkg.sv */
// package: constants, types and state encoding for the shared memory controller
package shared_mem_select_n_ctrl_pkg;
   // ----------------------------------------------------------------
   // memory geometry
   // ----------------------------------------------------------------
   localparam int MEM_ADDR_W  = 13;
   localparam int MEM_DEPTH   = 8192;
   localparam int DATA_W      = 8;
   localparam int HOST_ADDR_W = 20;
   localparam int ADDR_HI_W   = MEM_ADDR_W - DATA_W;

   // ----------------------------------------------------------------
   // coax controller register indices (strobe numbers)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_READ_BYTE  = 8'h16;
   localparam logic [7:0] REG_WRITE_BYTE = 8'h17;
   localparam logic [7:0] REG_ADDR_LOW   = 8'h18;
   localparam logic [7:0] REG_READ_REQ   = 8'h18;
   localparam logic [7:0] REG_ADDR_HIGH  = 8'h19;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int ACCESS_CLOCKS = 3;
   localparam int MAX_HOST_MHZ  = 16;

   // ----------------------------------------------------------------
   // host bus status codes
   // ----------------------------------------------------------------
   localparam logic [2:0] ST_FETCH     = 3'h4;
   localparam logic [2:0] ST_MEM_READ  = 3'h5;
   localparam logic [2:0] ST_MEM_WRITE = 3'h6;

   // access sequencer states, one-hot
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_ADDR = 4'h2,
      S_DATA = 4'h4,
      S_DONE = 4'h8
   } seq_state_t;

   // whole controller state
   typedef struct packed {
      seq_state_t              state;
      logic                    owner_coax;
      logic                    is_write;
      logic [2:0]              rd_sync;
      logic [2:0]              wr_sync;
      logic                    rd_filt;
      logic                    wr_filt;
      logic                    coax_req;
      logic                    coax_wr;
      logic [MEM_ADDR_W-1:0]   coax_addr;
      logic [DATA_W-1:0]       coax_wdata;
      logic [DATA_W-1:0]       coax_rdata;
      logic [DATA_W-1:0]       host_rdata;
      logic                    host_ready;
      logic                    lane_odd;
   } ctrl_state_t;

   // shared memory port signals
   typedef struct packed {
      logic                  cs_n;
      logic                  we_n;
      logic                  oe_n;
      logic [MEM_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     wdata;
   } mem_port_t;
endpackage

/* test/dual_port_ram_controller_test.sv */
// self-checking bench for the shared memory controller
`timescale 1ns/10ps
module dual_port_ram_controller_test
   import shared_mem_select_n_ctrl_pkg::*;
;
   logic clk, srst, sel_n, dls, ready, lle, lhe, coe, cae, hae, cs_n, we_n, oe_n;
   logic [2:0]  status;
   logic [19:0] haddr;
   logic [7:0]  wlo, whi, hrd, cwd, crd, mwd, mrd;
   logic [4:0]  stb_n;
   logic [12:0] abus;
   int          error_cnt, num_checks;
   always #4 clk = ~clk;
   shared_mem_select_n_ctrl DUT (.clk(clk), .srst(srst), .shared_mem_select_n(sel_n), .host_status(status),
      .host_addr(haddr), .host_wdata_low(wlo), .host_wdata_high(whi), .delayed_latch_strobe(dls),
      .shared_mem_host_ready(ready), .host_rdata(hrd), .host_lane_low_en(lle), .host_lane_high_en(lhe),
      .write_addr_low_strobe_n(stb_n[0]), .write_addr_high_strobe_n(stb_n[1]),
      .write_byte_strobe_n(stb_n[2]), .read_request_strobe_n(stb_n[3]), .read_byte_strobe_n(stb_n[4]),
      .coax_wdata(cwd), .coax_rdata(crd), .coax_rdata_oe(coe), .coax_addr_enable_n(cae),
      .host_addr_enable_n(hae), .shared_mem_addr_bus(abus), .mem_cs_n(cs_n), .mem_we_n(we_n),
      .mem_oe_n(oe_n), .mem_wdata(mwd), .mem_rdata(mrd));
   shared_sram_model sram (.clk(clk), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(abus), .wdata(mwd),
      .rdata(mrd));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // sample a little after the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one host access held until ready; lat 0 means latency not judged
   task automatic host(input logic [2:0] st, input logic [19:0] a, input logic [7:0] d, input int lat);
      int n;
      @(posedge clk);
      sel_n  <= 1'b0;
      status <= st;
      haddr  <= a;
      wlo    <= a[0] ? ~d : d; // unused lane carries a wrong byte
      whi    <= a[0] ? d : ~d;
      n = 0;
      do begin
         tick(1);
         n++;
         if (hae === 1'b0) begin
            chk("lane_low", !a[0], lle);
            chk("lane_high", a[0], lhe);
            chk("host_addr_bus", a[12:0], abus);
            chk("coax_en_off", 1, cae);
         end
      end while (ready !== 1'b1 && n < 16);
      chk("host_done", 1, ready);
      if (n >= 16)
         print_verdict();
      if (lat > 0)
         chk("host_latency", ACCESS_CLOCKS + 1, n);
      @(posedge clk);
      sel_n  <= 1'b1;
      status <= 3'h0;
      dls    <= 1'b1;
      @(posedge clk);
      dls <= 1'b0;
      tick(1);
      chk("ready_clear", 0, ready);
      if (st != ST_MEM_WRITE)
         chk("host_rdata", d, hrd);
      tick(4);
   endtask
   task automatic pulse(input int b, input logic [7:0] d);
      @(posedge clk);
      stb_n[b] <= 1'b0;
      cwd      <= d;
      repeat (2) @(posedge clk);
      stb_n[b] <= 1'b1;
      tick(1);
   endtask
   // coax access: address first, then the data request
   task automatic coax(input logic wr, input logic [12:0] a, input logic [7:0] d);
      int n;
      pulse(0, a[7:0]);
      pulse(1, {3'h0, a[12:8]});
      pulse(wr ? 2 : 3, d);
      n = 0;
      while (cae !== 1'b0 && n < 30) begin
         tick(1);
         n++;
      end
      chk("coax_start", 1, n < 30);
      if (n >= 30)
         print_verdict();
      chk("coax_addr_bus", a, abus);
      chk("host_en_off", 1, hae);
      tick(4);
      chk("coax_rdata", d, crd);
      chk("coax_idle", 1, cae);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      srst = 1'b1;
      sel_n = 1'b1;
      status = 3'h0;
      haddr = 20'h00000;
      wlo = 8'h00;
      whi = 8'h00;
      dls = 1'b0;
      stb_n = 5'h1f;
      cwd = 8'h00;
      error_cnt = 0;
      num_checks = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      tick(1);
      chk("ready_reset", 0, ready);
      host(ST_MEM_WRITE, 20'h00100, 8'ha5, 5);
      host(ST_MEM_WRITE, 20'h00101, 8'h3c, 5);
      host(ST_MEM_WRITE, 20'hf1fff, 8'h81, 5);
      host(ST_MEM_READ, 20'h00100, 8'ha5, 5);
      host(ST_FETCH, 20'h00101, 8'h3c, 5);
      host(ST_MEM_READ, 20'h01fff, 8'h81, 5);
      coax(1'b0, 13'h0101, 8'h3c);
      coax(1'b1, 13'h0800, 8'h5a);
      coax(1'b1, 13'h1801, 8'hc3);
      coax(1'b0, 13'h1fff, 8'h81);
      host(ST_MEM_READ, 20'h00800, 8'h5a, 5);
      host(ST_MEM_READ, 20'h01801, 8'hc3, 5);
      // other status codes and a deselected decode start nothing
      @(posedge clk);
      sel_n  <= 1'b0;
      status <= 3'h2;
      tick(6);
      chk("no_start_status", 1, hae);
      @(posedge clk);
      sel_n  <= 1'b1;
      status <= ST_MEM_READ;
      tick(6);
      chk("no_start_select", 0, ready);
      @(posedge clk);
      status <= 3'h0;
      // both masters back to back: host asks as the coax access ends; each served whole, one at a time
      fork
         coax(1'b1, 13'h0444, 8'h96);
         begin
            tick(18);
            host(ST_MEM_WRITE, 20'h00445, 8'h69, 0);
         end
      join
      host(ST_MEM_READ, 20'h00444, 8'h96, 5);
      host(ST_MEM_READ, 20'h00445, 8'h69, 5);
      // read byte strobe turns the coax data driver on
      @(posedge clk);
      stb_n[4] <= 1'b0;
      tick(1);
      chk("coax_oe", 1, coe);
      @(posedge clk);
      stb_n[4] <= 1'b1;
      tick(1);
      chk("coax_oe_off", 0, coe);
      print_verdict();
   end
endmodule // dual_port_ram_controller_test

/* test/shared_sram_model.sv */
// behavioural 8k x 8 static memory on the far side of the controller
`timescale 1ns/10ps
module shared_sram_model
   import shared_mem_select_n_ctrl_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  cs_n,
   input  wire logic                  we_n,
   input  wire logic                  oe_n,
   input  wire logic [MEM_ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0]     wdata,
   output logic [DATA_W-1:0]          rdata
);
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] last = 8'h00;
   // store while selected for write; remember last byte put out
   always @(posedge clk) begin
      if (!cs_n && !we_n)
         mem[addr] <= wdata;
      if (!cs_n && !oe_n)
         last <= mem[addr];
   end
   // output is short-lived: inverse of last byte once deselected
   assign rdata = (!cs_n && !oe_n) ? mem[addr] : ~last;
endmodule // shared_sram_model
